// >>> core/adcs_defs.svh
// Timing constants and field positions for the conversion sequencer
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH
// Clock cycles of the 250 MHz clock per half_cpu_period; parameterised to shorten sims
`define ADCS_CLK_PERIOD_PS 4000
`define ADCS_TCL_PS 4000
`define ADCS_TCL_DIV ((`ADCS_TCL_PS + `ADCS_CLK_PERIOD_PS - 1) / `ADCS_CLK_PERIOD_PS)
// Conversion step lengths in half_cpu_period units
`define ADCS_CC_CODE00 11'h018
`define ADCS_CC_CODE10 11'h060
`define ADCS_CC_CODE11 11'h030
`define ADCS_SAMPLE_PERIODS 11'h002
`define ADCS_DECISION_STEPS 4'hA
`define ADCS_EQUAL_STEPS 4'h4
`define ADCS_LOAD_TCL 11'h004
// Reserved conversion select code and the first trial of each conversion
`define ADCS_CC_RESERVED 2'h1
`define ADCS_TRIAL_START 10'h200
`define ADCS_TRIAL_BIT 4'h9
// Field positions inside the upper four bits of converter_control_register
`define ADCS_CC_SEL_MSB 3
`define ADCS_CC_SEL_LSB 2
`define ADCS_SC_SEL_MSB 1
`define ADCS_SC_SEL_LSB 0
`define ADCS_RES_ZERO 10'h000
`define ADCS_RES_FULL 10'h3FF
`endif

// >>> core/adcs_pkg.sv
// Types shared by the conversion sequencer
package adcs_pkg;
  typedef enum logic [2:0] {
    ADCS_IDLE = 3'h0,
    ADCS_SAMPLE = 3'h1,
    ADCS_CONVERT = 3'h3,
    ADCS_EQUAL = 3'h2,
    ADCS_LOAD = 3'h6
  } adcs_state_e;
  typedef struct packed {
    logic [1:0] conversion_clock_select;
    logic [1:0] sample_clock_select;
  } adcs_cfg_s;
endpackage : adcs_pkg

// >>> core/adcs_tcl_div.sv
// Divider producing one enable pulse per half_cpu_period
`timescale 1ns/10ps
module adcs_tcl_div #(
  parameter int unsigned DIV = 1
) (
  input wire logic clock,
  input wire logic rst_b,
  output logic tcl_en
);
  logic [7:0] cnt_r;
  wire cnt_wrap = (cnt_r == 8'(DIV - 1));
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_r <= 8'h00;
      tcl_en <= 1'b0;
    end else begin
      cnt_r <= cnt_wrap ? 8'h00 : cnt_r + 8'h01;
      tcl_en <= cnt_wrap;
    end
  end
endmodule : adcs_tcl_div

// >>> core/adcs_seq.sv
// Successive-approximation conversion timing sequencer
// Operation
// - Conversion select code 00, 10, 11 gives a step of 24, 96, 48 half periods; 01 is reserved.
// - Sample select code 00..11 makes the sample period 1, 2, 4 or 8 conversion steps.
// - A conversion begins with sampling that lasts two sample periods.
// - Ten decision steps, one per conversion step, resolve the 10-bit result.
// - Four more conversion steps follow for level equalisation.
// - A conversion lasts 14 steps plus two sample periods plus 4 half periods.
// - Both select fields sit in the upper four bits of the control register.
// - Input below ground gives all zeros, above reference gives all ones.
// - After sampling the held value alone decides the result.
// - The time unit is one half period of the CPU clock.
`timescale 1ns/10ps
`include "adcs_defs.svh"
module adcs_seq
  import adcs_pkg::*;
#(
  parameter int unsigned TCL_DIV = `ADCS_TCL_DIV
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [3:0] ctrl_upper,
  input wire logic cmp_above,
  input wire logic in_below_agnd,
  input wire logic in_above_aref,
  output logic sample_en,
  output logic [9:0] dac_code,
  output logic busy,
  output logic done,
  output logic [9:0] result,
  output logic cfg_reserved
);
  function automatic logic [10:0] cc_len(input logic [1:0] sel);
    case (sel)
      2'b10: cc_len = `ADCS_CC_CODE10;
      2'b11: cc_len = `ADCS_CC_CODE11;
      default: cc_len = `ADCS_CC_CODE00;
    endcase
  endfunction : cc_len

  function automatic logic [10:0] sample_len(input adcs_cfg_s c);
    sample_len = 11'(`ADCS_SAMPLE_PERIODS * (cc_len(c.conversion_clock_select)
                 << c.sample_clock_select));
  endfunction : sample_len

  // One decision: keep or drop the bit under trial, then raise the next lower bit
  function automatic logic [9:0] sar_trial(input logic [9:0] code, input logic [9:0] mask,
                                           input logic keep, input logic last);
    logic [9:0] kept;
    kept = keep ? code : (code & ~mask);
    sar_trial = last ? kept : (kept | (mask >> 1));
  endfunction : sar_trial

  // Out-of-range inputs force the result to either end of the scale
  function automatic logic [9:0] range_clamp(input logic [9:0] code, input logic below,
                                             input logic above);
    if (below) begin
      range_clamp = `ADCS_RES_ZERO;
    end else if (above) begin
      range_clamp = `ADCS_RES_FULL;
    end else begin
      range_clamp = code;
    end
  endfunction : range_clamp

  // Reserved conversion select code runs with the shortest step
  function automatic logic cc_reserved(input logic [1:0] sel);
    cc_reserved = (sel == `ADCS_CC_RESERVED);
  endfunction : cc_reserved

  adcs_state_e state_r, state_nxt;
  adcs_cfg_s cfg_r;
  logic [10:0] cnt_r;
  logic [3:0] step_r;
  logic [3:0] bit_r;
  logic [9:0] sar_r;
  logic below_r, above_r;
  logic [2:0] s1_r, s2_r;
  logic tcl_en;

  // Divider gives the half_cpu_period time base
  adcs_tcl_div #(.DIV(TCL_DIV)) u_div (
    .clock(clock),
    .rst_b(rst_b),
    .tcl_en(tcl_en)
  );

  // Analog-side levels pass two flops before use
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else begin
      s1_r <= {cmp_above, in_below_agnd, in_above_aref};
      s2_r <= s1_r;
    end
  end
  wire cmp_q = s2_r[2];
  wire below_q = s2_r[1];
  wire above_q = s2_r[0];

  // State decodes shared by the counters, the datapath and the outputs
  wire in_idle = (state_r == ADCS_IDLE);
  wire in_sample = (state_r == ADCS_SAMPLE);
  wire in_convert = (state_r == ADCS_CONVERT);
  wire in_load = (state_r == ADCS_LOAD);

  // Segment length in enable ticks for the current phase
  wire [10:0] cc_cur = cc_len(cfg_r.conversion_clock_select);
  wire [10:0] target = in_sample ? sample_len(cfg_r) :
                       in_load ? `ADCS_LOAD_TCL : cc_cur;
  wire seg_end = tcl_en && (cnt_r == target - 11'h001);
  wire start_ok = start && in_idle;
  wire sample_end = in_sample && seg_end;
  wire step_end = in_convert && seg_end;
  wire load_end = in_load && seg_end;
  wire last_dec = (step_r == `ADCS_DECISION_STEPS - 4'h1);
  wire last_eq = (step_r == `ADCS_EQUAL_STEPS - 4'h1);
  wire state_change = (state_nxt != state_r);

  // Successive approximation datapath
  wire [9:0] bit_mask = 10'h001 << bit_r;
  wire [9:0] next_trial = sar_trial(sar_r, bit_mask, cmp_q, bit_r == 4'h0);
  wire [9:0] final_code = range_clamp(sar_r, below_r, above_r);
  wire [1:0] cc_sel_in = ctrl_upper[`ADCS_CC_SEL_MSB:`ADCS_CC_SEL_LSB];
  wire [1:0] sc_sel_in = ctrl_upper[`ADCS_SC_SEL_MSB:`ADCS_SC_SEL_LSB];

  // Next values of the registered outputs
  wire sample_en_nxt = (state_nxt == ADCS_SAMPLE);
  wire busy_nxt = (state_nxt != ADCS_IDLE);
  wire [9:0] dac_code_nxt = step_end ? next_trial :
                            sample_end ? `ADCS_TRIAL_START : dac_code;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADCS_IDLE: if (start_ok) state_nxt = ADCS_SAMPLE;
      ADCS_SAMPLE: if (seg_end) state_nxt = ADCS_CONVERT;
      ADCS_CONVERT: if (seg_end && last_dec) state_nxt = ADCS_EQUAL;
      ADCS_EQUAL: if (seg_end && last_eq) state_nxt = ADCS_LOAD;
      ADCS_LOAD: if (seg_end) state_nxt = ADCS_IDLE;
      default: state_nxt = ADCS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= ADCS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Tick counter restarts at every segment boundary
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt_r <= 11'h000;
    end else if (start_ok || seg_end) begin
      cnt_r <= 11'h000;
    end else if (tcl_en && !in_idle) begin
      cnt_r <= cnt_r + 11'h001;
    end
  end

  // Step counter numbers the decision and equalisation steps of a phase
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      step_r <= 4'h0;
    end else if (state_change) begin
      step_r <= 4'h0;
    end else if (seg_end) begin
      step_r <= step_r + 4'h1;
    end
  end

  // Configuration is captured from the upper control bits at start
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cfg_r <= '0;
      cfg_reserved <= 1'b0;
    end else if (start_ok) begin
      cfg_r.conversion_clock_select <= cc_sel_in;
      cfg_r.sample_clock_select <= sc_sel_in;
      cfg_reserved <= cc_reserved(cc_sel_in);
    end
  end

  // Approximation register starts at mid-scale when sampling closes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sar_r <= 10'h000;
      bit_r <= 4'h0;
    end else if (sample_end) begin
      sar_r <= `ADCS_TRIAL_START;
      bit_r <= `ADCS_TRIAL_BIT;
    end else if (step_end) begin
      sar_r <= next_trial;
      if (bit_r != 4'h0) begin
        bit_r <= bit_r - 4'h1;
      end
    end
  end

  // Range flags freeze with the sample so later input swings cannot reach the result
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      below_r <= 1'b0;
      above_r <= 1'b0;
    end else if (sample_end) begin
      below_r <= below_q;
      above_r <= above_q;
    end
  end

  // Phase outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sample_en <= 1'b0;
      busy <= 1'b0;
    end else begin
      sample_en <= sample_en_nxt;
      busy <= busy_nxt;
    end
  end

  // Trial code seen by the comparator
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      dac_code <= 10'h000;
    end else begin
      dac_code <= dac_code_nxt;
    end
  end

  // Result register and its load strobe
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      done <= 1'b0;
      result <= 10'h000;
    end else begin
      done <= load_end;
      if (load_end) begin
        result <= final_code;
      end
    end
  end
endmodule : adcs_seq

// >>> bench/adcs_model.sv
// Analog source with sample-and-hold and comparator
`timescale 1ns/10ps
module adcs_model (
  input wire logic clock,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] vin,
  output logic cmp_above
);
  logic [9:0] held_r = 10'h000;
  always @(posedge clock) begin
    if (sample_en) held_r <= vin;
  end
  assign cmp_above = (held_r >= dac_code);
endmodule : adcs_model

// >>> bench/adcs_seq_asserts.sv
// Port assertions for the conversion sequencer
`timescale 1ns/10ps
module adcs_seq_asserts
  import adcs_pkg::*;
#(parameter int unsigned TCL_DIV = 1) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [3:0] ctrl_upper,
  input wire logic sample_en,
  input wire logic [9:0] dac_code,
  input wire logic busy,
  input wire logic done,
  input wire logic [9:0] result,
  input wire logic cfg_reserved
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [11:0] cc_r;
  logic [11:0] n_r;
  logic [11:0] sl_r;
  logic [1:0] sc_r;
  logic rsv_r;
  always_ff @(posedge clock) begin
    if (start && !busy) begin
      cc_r <= ctrl_upper[3] ? (ctrl_upper[2] ? 12'h030 : 12'h060) : 12'h018;
      sc_r <= ctrl_upper[1:0];
      rsv_r <= (ctrl_upper[3:2] == 2'h1);
    end
    n_r <= sample_en ? 12'h000 : n_r + 12'h001;
    sl_r <= sample_en ? sl_r + 12'h001 : 12'h000;
  end
  sequence s_launch;
    start && !busy;
  endsequence
  sequence s_sample_end;
    $fell(sample_en) && busy;
  endsequence
  a_busy_start: assert property (s_launch |=> busy && sample_en)
    else $error("no busy");
  a_done_pulse: assert property (done |=> !done) else $error("long done");
  a_done_busy: assert property (done |-> !busy && $past(busy)) else $error("busy");
  a_first_trial: assert property (s_sample_end |-> dac_code == 10'h200)
    else $error("trial");
  a_sample_min: assert property ($rose(sample_en) |-> sample_en[*8]) else $error("short");
  a_sample_len: assert property (s_sample_end |-> sl_r == 2 * (cc_r << sc_r))
    else $error("sample length");
  a_result_hold: assert property ($changed(result) |-> done) else $error("result");
  a_reserved_flag: assert property (s_launch |=> cfg_reserved == rsv_r)
    else $error("reserved");
  a_conv_len: assert property (done |-> n_r >= 14 * cc_r * TCL_DIV + 1 &&
    n_r <= 14 * cc_r * TCL_DIV + 6) else $error("steps");
endmodule : adcs_seq_asserts
bind adcs_seq adcs_seq_asserts #(.TCL_DIV(TCL_DIV)) adcs_seq_asserts_inst (.clock(clock),
  .rst_b(rst_b), .start(start), .ctrl_upper(ctrl_upper), .sample_en(sample_en),
  .dac_code(dac_code), .busy(busy), .done(done), .result(result), .cfg_reserved(cfg_reserved));

// >>> bench/tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/10ps
module tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic [3:0] ctrl_upper = 4'h0;
  logic in_below_agnd = 1'b0;
  logic in_above_aref = 1'b0;
  logic [9:0] vin = 10'h000;
  logic cmp_above, sample_en, busy, done, cfg_reserved;
  logic [9:0] dac_code, result, v;
  int miscompares = 0;
  int check_count = 0;
  int seed = 32'h7E7A;
  adcs_seq #(.TCL_DIV(1)) adcs_seq_inst (.clock(clock), .rst_b(rst_b), .start(start),
    .ctrl_upper(ctrl_upper), .cmp_above(cmp_above), .in_below_agnd(in_below_agnd),
    .in_above_aref(in_above_aref), .sample_en(sample_en), .dac_code(dac_code),
    .busy(busy), .done(done), .result(result), .cfg_reserved(cfg_reserved));
  adcs_model adcs_model_inst (.clock(clock), .sample_en(sample_en), .dac_code(dac_code),
    .vin(vin), .cmp_above(cmp_above));
  initial forever #2 clock = ~clock;
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  function automatic int t_exp(input logic [3:0] c);
    int cc;
    cc = c[3] ? (c[2] ? 48 : 96) : 24;
    return ((2 * cc) << c[1:0]) + 14 * cc + 4;
  endfunction : t_exp
  task automatic conv(input logic [3:0] c, input logic [9:0] x, input logic b, input logic a);
    int cyc;
    int t;
    t = t_exp(c);
    cyc = 0;
    ctrl_upper = c;
    vin = x;
    in_below_agnd = b;
    in_above_aref = a;
    do begin
      start = (cyc == 0 || cyc == 3);
      if (cyc == 3) ctrl_upper = ~c;
      if (sample_en === 1'b0 && cyc > 4) in_below_agnd = ~b;
      if (sample_en === 1'b0 && cyc > 4) in_above_aref = ~a;
      @(negedge clock);
      cyc++;
    end while (done !== 1'b1 && cyc < 4000);
    chk("cycles", {11'h000, cyc >= t && cyc <= t + 2}, 12'h001);
    chk("result", {2'h0, result}, {2'h0, b ? 10'h000 : a ? 10'h3FF : x});
    chk("reserved", {11'h000, cfg_reserved}, {11'h000, c[3:2] == 2'h1});
    chk("busy", {11'h000, busy}, 12'h000);
  endtask : conv
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    for (int i = 0; i < 16; i++) begin
      v = 10'($random(seed));
      conv(i[3:0], i == 1 ? 10'h000 : i == 2 ? 10'h3FF : v, i == 4 || i == 6, i == 5 || i == 6);
      $display("test %0d done", i);
    end
    close_out();
  end
endmodule : tb
